// *** rtl/rms_fifo.sv ***
/*
  rms_fifo: flip-flop FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and a single clock domain.
*/
`timescale 1ns/10ps
module rms_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // drain side
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0]      count_q, count_d;
  logic             notFull_q, notFull_d;
  logic             push, pop;

  assign push     = inValid & notFull_q;
  assign pop      = outValid & outReady;
  assign inReady  = notFull_q;
  assign outValid = (count_q != '0);
  assign outData  = mem_q[rdPtr_q];

  // ==========================================================
  // pointers and fill level; ready is registered so it never loops back
  always_comb begin
    wrPtr_d   = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
    rdPtr_d   = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
    count_d   = (AW+1)'(count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    notFull_d = (count_d != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q   <= '0;
      rdPtr_q   <= '0;
      count_q   <= '0;
      notFull_q <= 1'b1;
    end else begin
      wrPtr_q   <= wrPtr_d;
      rdPtr_q   <= rdPtr_d;
      count_q   <= count_d;
      notFull_q <= notFull_d;
    end
  end

  // storage needs no reset: nothing reads a word before it is written
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end
endmodule // rms_fifo

// *** rtl/rms_pkg.sv ***
/*
  rms_pkg: constants, character codes, opcodes and types shared by the
  remote message sync block, its assertion checker and its test bench.
  Assumes a 20 MHz system clock.
*/
package rms_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ     = 20_000_000;
  localparam int SETTLE_MS  = 500;
  localparam int SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;

  // ==========================================================
  // layout and sizes
  localparam int RX_DEPTH   = 32;
  localparam int STR_DEPTH  = 16;
  localparam int SETTLE_BIT = 3;
  localparam int ESB_BIT    = 3;

  // ==========================================================
  // character codes
  localparam logic [7:0] CH_NL    = 8'h0A;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_DQ    = 8'h22;
  localparam logic [7:0] CH_HASH  = 8'h23;
  localparam logic [7:0] CH_SQ    = 8'h27;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_TWO   = 8'h32;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_B     = 8'h42;
  localparam logic [7:0] CH_F     = 8'h46;
  localparam logic [7:0] CH_H     = 8'h48;
  localparam logic [7:0] CH_N     = 8'h4E;
  localparam logic [7:0] CH_Q     = 8'h51;

  // ==========================================================
  // command opcodes (first character of a message unit)
  localparam logic [7:0] OP_EEMASK   = 8'h45; // event_enable_mask_cmd
  localparam logic [7:0] OP_EEMASK_Q = 8'h65;
  localparam logic [7:0] OP_EVREAD   = 8'h52; // event_read_clear_query
  localparam logic [7:0] OP_WAIT     = 8'h57; // event_wait_cmd
  localparam logic [7:0] OP_WAIT_Q   = 8'h77; // event_wait_query
  localparam logic [7:0] OP_HEADER   = 8'h48; // header_attach_cmd
  localparam logic [7:0] OP_HEADER_Q = 8'h68;
  localparam logic [7:0] OP_LONG     = 8'h56; // long_form_cmd
  localparam logic [7:0] OP_REMOTE   = 8'h4D; // remote_select_cmd
  localparam logic [7:0] OP_SRE      = 8'h53;
  localparam logic [7:0] OP_FILTER   = 8'h46;
  localparam logic [7:0] OP_LEVEL    = 8'h4C;
  localparam logic [7:0] OP_OUTPUT   = 8'h4F;
  localparam logic [7:0] OP_TEXT     = 8'h54;
  localparam logic [7:0] OP_BLOCK    = 8'h42;
  localparam logic [7:0] OP_COND     = 8'h43;

  // ==========================================================
  // transition filter codes and reset values
  localparam logic [1:0]  FLT_NONE  = 2'h0;
  localparam logic [1:0]  FLT_RISE  = 2'h1;
  localparam logic [1:0]  FLT_FALL  = 2'h2;
  localparam logic [1:0]  FLT_BOTH  = 2'h3;
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [4:0]  RADIX_DEC = 5'h0A;

  // ==========================================================
  // types
  typedef enum logic [6:0] {
    ST_OP   = 7'h01,
    ST_ARG  = 7'h02,
    ST_STR  = 7'h04,
    ST_STRQ = 7'h08,
    ST_EXEC = 7'h10,
    ST_WAIT = 7'h20,
    ST_RESP = 7'h40
  } rms_state_e;

  typedef enum logic [2:0] {
    RK_DEC = 3'h1,
    RK_STR = 3'h2,
    RK_BLK = 3'h4
  } rms_rkind_e;

  typedef struct packed {
    logic       header;
    logic       longForm;
    logic       remote;
    logic [1:0] filter;
  } rms_cfg_s;

  localparam rms_cfg_s CFG_RST = '{header: 1'b1, longForm: 1'b0, remote: 1'b0,
                                   filter: FLT_NONE};
endpackage : rms_pkg

// *** rtl/rms_remote_message_sync.sv ***
/*
  rms_remote_message_sync: byte-stream command interpreter with output
  settling flag, transition filter, extended event register, service
  request and blocking event wait. Assumes rx/tx bytes are on this clock.
*/
// Functional notes
// - text argument enclosed by matching quote pair
// - doubled delimiter collapses to one literal
// - text responses always wrapped in double quotes
// - unclosed text swallows rest, never errors
// - block data only sent, never parsed
// - block: hash, digit count, length, payload
// - commands run strictly one after another
// - condition bit 3 high ~500 ms after output turn-on or level command
// - falling filter sets event bit 3
// - enable mask gates events into summary
// - event register read returns then clears
// - service request follows enabled summary bit
// - wait command blocks until masked event
// - wait query answers once event occurs
// - header setting prefixes responses, readable
// - long form setting doubles the opcode in the header
// - remote select on means remote control
// - masks accepted any radix, answered decimal
`timescale 1ns/10ps
module rms_remote_message_sync import rms_pkg::*; #(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int FIFO_DEPTH    = RX_DEPTH
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // command byte stream in
  input  wire logic [7:0]  rxData,
  input  wire logic        rxValid,
  output logic             rxReady,
  // response byte stream out
  output logic [7:0]       txData,
  output logic             txValid,
  input  wire logic        txReady,
  // status
  output rms_cfg_s         cfg,
  output logic [15:0]      condReg,
  output logic [15:0]      eventReg,
  output logic             srq,
  output logic             outputOn
);
  localparam int SW = $clog2(STR_DEPTH);

  // ==========================================================
  // receive FIFO and settle timer
  logic [7:0] inByte;
  logic       inValid, inPop, settleStart, settling;

  rms_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxFifo (
    .clock    (clock),
    .rst_b    (rst_b),
    .inData   (rxData),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .outData  (inByte),
    .outValid (inValid),
    .outReady (inPop)
  );

  rms_settle_timer #(.CYCLES(SETTLE_CYCLES)) u_settle (
    .clock (clock),
    .rst_b (rst_b),
    .start (settleStart),
    .busy  (settling)
  );

  // ==========================================================
  // helpers
  function automatic logic [4:0] digVal(input logic [7:0] b);
    if (b >= CH_ZERO && b <= 8'h39) begin
      digVal = 5'(b - CH_ZERO);
    end else if (b >= CH_A && b <= CH_F) begin
      digVal = 5'(b - CH_A + 8'h0A);
    end else begin
      digVal = 5'h1F;
    end
  endfunction

  function automatic logic [19:0] toBcd(input logic [15:0] v);
    logic [35:0] s;
    s = {20'h0_0000, v};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 5; d++) begin
        if (s[16+4*d +: 4] >= 4'h5) begin
          s[16+4*d +: 4] = s[16+4*d +: 4] + 4'h3;
        end
      end
      s = {s[34:0], 1'b0};
    end
    toBcd = s[35:16];
  endfunction

  // ==========================================================
  // parser, executor and response state
  rms_state_e  state_q, state_d;
  rms_rkind_e  rKind_q, rKind_d;
  rms_cfg_s    cfg_q, cfg_d;
  logic [7:0]  op_q, op_d, delim_q, delim_d, txData_q, txData_d;
  logic [7:0]  strBuf_q [STR_DEPTH];
  logic [7:0]  strBuf_d [STR_DEPTH];
  logic [15:0] acc_q, acc_d, eeMask_q, eeMask_d, waitMask_q, waitMask_d;
  logic [15:0] rVal_q, rVal_d;
  logic [7:0]  sreMask_q, sreMask_d;
  logic [4:0]  radix_q, radix_d;
  logic [SW:0] strLen_q, strLen_d;
  logic [5:0]  rPos_q, rPos_d;
  logic        hash_q, hash_d, waitQ_q, waitQ_d, outOn_q, outOn_d;
  logic        txValid_q, txValid_d, evReadClr;
  logic [15:0] eventReg_q, eventReg_d;

  // response byte generator
  logic [19:0] bcd;
  logic [5:0]  hdrLen, bodyLen, total, q;
  logic [2:0]  nd;
  logic [7:0]  rByte, bodyTens, bodyOnes;

  always_comb begin
    bcd = toBcd(rVal_q);
    nd  = 3'h1;
    for (int d = 1; d < 5; d++) begin
      if (bcd[4*d +: 4] != 4'h0) begin
        nd = 3'(d + 1);
      end
    end
    hdrLen   = cfg_q.header ? (cfg_q.longForm ? 6'h04 : 6'h03) : 6'h00;
    bodyTens = CH_ZERO + 8'(strLen_q / 10);
    bodyOnes = CH_ZERO + 8'(strLen_q % 10);
    case (rKind_q)
      RK_STR:  bodyLen = 6'(strLen_q) + 6'h02;
      RK_BLK:  bodyLen = 6'(strLen_q) + 6'h04;
      default: bodyLen = 6'(nd);
    endcase
    total = hdrLen + bodyLen + 6'h01;
    q     = rPos_q - hdrLen;
    if (rPos_q < hdrLen) begin
      // short header is ":X ", long form spells ":XX "
      rByte = (rPos_q == 6'h00) ? CH_COLON : (rPos_q == hdrLen - 6'h01) ? CH_SP : op_q;
    end else if (q >= bodyLen) begin
      rByte = CH_NL; // message_terminator of the response
    end else begin
      case (rKind_q)
        RK_STR: begin
          rByte = (q == 6'h00 || q == bodyLen - 6'h01) ? CH_DQ
                                                       : strBuf_q[SW'(q - 6'h01)];
        end
        RK_BLK: begin
          case (q)
            6'h00:   rByte = CH_HASH;
            6'h01:   rByte = CH_TWO;    // two length digits follow
            6'h02:   rByte = bodyTens;
            6'h03:   rByte = bodyOnes;
            default: rByte = strBuf_q[SW'(q - 6'h04)];
          endcase
        end
        default: begin
          rByte = CH_ZERO + 8'(4'(bcd >> (4 * (nd - 3'h1 - 3'(q)))));
        end
      endcase
    end
  end

  // ==========================================================
  // command sequencer: pop only in parse states, so one unit at a time
  always_comb begin
    state_d     = state_q;
    op_d        = op_q;
    delim_d     = delim_q;
    acc_d       = acc_q;
    radix_d     = radix_q;
    hash_d      = hash_q;
    strLen_d    = strLen_q;
    strBuf_d    = strBuf_q;
    cfg_d       = cfg_q;
    eeMask_d    = eeMask_q;
    sreMask_d   = sreMask_q;
    waitMask_d  = waitMask_q;
    waitQ_d     = waitQ_q;
    outOn_d     = outOn_q;
    rKind_d     = rKind_q;
    rVal_d      = rVal_q;
    rPos_d      = rPos_q;
    txData_d    = txData_q;
    txValid_d   = txValid_q;
    inPop       = 1'b0;
    evReadClr   = 1'b0;
    settleStart = 1'b0;
    case (state_q)
      ST_OP: begin
        inPop = 1'b1;
        if (inValid && inByte != CH_SEMI && inByte != CH_NL && inByte != CH_SP) begin
          op_d    = inByte;
          acc_d   = MASK_RST;
          radix_d = RADIX_DEC;
          hash_d  = 1'b0;
          state_d = ST_ARG;
        end
      end
      ST_ARG, ST_STRQ: begin
        inPop = 1'b1;
        if (inValid) begin
          state_d = ST_ARG; // a closed quote falls back to plain argument bytes
          if (state_q == ST_STRQ && inByte == delim_q) begin
            if (strLen_q < (SW+1)'(STR_DEPTH)) begin
              strBuf_d[SW'(strLen_q)] = inByte;
              strLen_d = strLen_q + 1'b1;
            end
            state_d = ST_STR;
          end else if (inByte == CH_SEMI || inByte == CH_NL) begin
            state_d = ST_EXEC;
          end else if (inByte == CH_DQ || inByte == CH_SQ) begin
            delim_d  = inByte;
            strLen_d = '0;
            state_d  = ST_STR;
          end else if (inByte == CH_HASH) begin
            hash_d = 1'b1;
          end else if (hash_q) begin
            hash_d  = 1'b0;
            radix_d = (inByte == CH_H) ? 5'h10 : (inByte == CH_Q) ? 5'h08 :
                      (inByte == CH_B) ? 5'h02 : RADIX_DEC;
          end else if (digVal(inByte) < radix_q) begin
            acc_d = 16'(acc_q * radix_q + digVal(inByte));
          end else if (inByte == CH_N) begin
            acc_d = 16'h0001; // ON
          end else if (inByte == CH_F) begin
            acc_d = 16'h0000; // OFF
          end
        end
      end
      ST_STR: begin
        inPop = 1'b1;
        if (inValid) begin
          if (inByte == delim_q) begin
            state_d = ST_STRQ;
          end else if (strLen_q < (SW+1)'(STR_DEPTH)) begin
            // terminators land here too while the quote is open
            strBuf_d[SW'(strLen_q)] = inByte;
            strLen_d = strLen_q + 1'b1;
          end
        end
      end
      ST_EXEC: begin
        state_d = ST_OP;
        rPos_d  = 6'h00;
        rKind_d = RK_DEC;
        case (op_q)
          OP_EEMASK:   eeMask_d = acc_q;
          OP_EEMASK_Q: begin rVal_d = eeMask_q; state_d = ST_RESP; end
          OP_EVREAD: begin
            rVal_d    = eventReg_q;
            evReadClr = 1'b1;
            state_d   = ST_RESP;
          end
          OP_WAIT, OP_WAIT_Q: begin
            waitMask_d = acc_q;
            waitQ_d    = (op_q == OP_WAIT_Q);
            state_d    = ST_WAIT;
          end
          OP_HEADER:   cfg_d.header = (acc_q != '0);
          OP_HEADER_Q: begin rVal_d = {15'h0000, cfg_q.header}; state_d = ST_RESP; end
          OP_LONG:     cfg_d.longForm = (acc_q != '0);
          OP_REMOTE:   cfg_d.remote = (acc_q != '0);
          OP_SRE:      sreMask_d = acc_q[7:0];
          OP_FILTER:   cfg_d.filter = acc_q[1:0];
          OP_LEVEL:    settleStart = 1'b1;
          OP_OUTPUT: begin
            outOn_d     = (acc_q != '0);
            settleStart = (acc_q != '0) && !outOn_q;
          end
          OP_TEXT:  begin rKind_d = RK_STR; state_d = ST_RESP; end
          OP_BLOCK: begin rKind_d = RK_BLK; state_d = ST_RESP; end
          OP_COND:  begin rVal_d = condReg; state_d = ST_RESP; end
          default:  state_d = ST_OP;
        endcase
      end
      ST_WAIT: begin
        // nothing is popped, so later units stay queued behind the wait
        if ((eventReg_q & waitMask_q) != '0) begin
          rVal_d  = eventReg_q & waitMask_q;
          state_d = waitQ_q ? ST_RESP : ST_OP;
        end
      end
      ST_RESP: begin
        if (!txValid_q || txReady) begin
          if (rPos_q < total) begin
            txData_d  = rByte;
            txValid_d = 1'b1;
            rPos_d    = rPos_q + 6'h01;
          end else begin
            txValid_d = 1'b0;
            state_d   = ST_OP;
          end
        end
      end
      default: state_d = ST_OP;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= ST_OP;
      op_q       <= 8'h00;
      delim_q    <= CH_DQ;
      acc_q      <= MASK_RST;
      radix_q    <= RADIX_DEC;
      hash_q     <= 1'b0;
      strLen_q   <= '0;
      strBuf_q   <= '{default: 8'h00};
      cfg_q      <= CFG_RST;
      eeMask_q   <= MASK_RST;
      sreMask_q  <= 8'h00;
      waitMask_q <= MASK_RST;
      waitQ_q    <= 1'b0;
      outOn_q    <= 1'b0;
      rKind_q    <= RK_DEC;
      rVal_q     <= 16'h0000;
      rPos_q     <= 6'h00;
      txData_q   <= 8'h00;
      txValid_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      op_q       <= op_d;
      delim_q    <= delim_d;
      acc_q      <= acc_d;
      radix_q    <= radix_d;
      hash_q     <= hash_d;
      strLen_q   <= strLen_d;
      strBuf_q   <= strBuf_d;
      cfg_q      <= cfg_d;
      eeMask_q   <= eeMask_d;
      sreMask_q  <= sreMask_d;
      waitMask_q <= waitMask_d;
      waitQ_q    <= waitQ_d;
      outOn_q    <= outOn_d;
      rKind_q    <= rKind_d;
      rVal_q     <= rVal_d;
      rPos_q     <= rPos_d;
      txData_q   <= txData_d;
      txValid_q  <= txValid_d;
    end
  end

  // ==========================================================
  // status model: filter, extended events, summary and service request
  logic prevSettle_q, srq_q, srq_d, evHit;
  logic [7:0] statusByte;

  always_comb begin
    evHit = ((cfg_q.filter == FLT_FALL || cfg_q.filter == FLT_BOTH) &&
             prevSettle_q && !settling) ||
            ((cfg_q.filter == FLT_RISE || cfg_q.filter == FLT_BOTH) &&
             !prevSettle_q && settling);
    // a new event in the clearing cycle survives the read
    eventReg_d = (evReadClr ? 16'h0000 : eventReg_q) |
                 (evHit ? 16'(1 << SETTLE_BIT) : 16'h0000);
    statusByte = 8'((((eventReg_q & eeMask_q) != '0) ? 8'h01 : 8'h00) << ESB_BIT);
    srq_d      = ((statusByte & sreMask_q) != '0);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prevSettle_q <= 1'b0;
      eventReg_q   <= 16'h0000;
      srq_q        <= 1'b0;
    end else begin
      prevSettle_q <= settling;
      eventReg_q   <= eventReg_d;
      srq_q        <= srq_d;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign condReg  = 16'(settling) << SETTLE_BIT;
  assign eventReg = eventReg_q;
  assign srq      = srq_q;
  assign cfg      = cfg_q;
  assign outputOn = outOn_q;
  assign txData   = txData_q;
  assign txValid  = txValid_q;
endmodule // rms_remote_message_sync

// *** rtl/rms_settle_timer.sv ***
/*
  rms_settle_timer: retriggerable one-shot that holds busy for CYCLES
  clocks after the last start pulse. Assumes start is a same-clock pulse.
*/
`timescale 1ns/10ps
module rms_settle_timer #(
  parameter int CYCLES = 10_000_000
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // control
  input  wire logic start,
  output logic      busy
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          busy_q, busy_d;

  assign busy = busy_q;

  // ==========================================================
  // each start reloads the full interval
  always_comb begin
    if (start) begin
      cnt_d = CW'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_d = CW'(cnt_q - 1'b1);
    end else begin
      cnt_d = cnt_q;
    end
    busy_d = (cnt_d != '0);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
    end
  end
endmodule // rms_settle_timer

// *** test/rms_asserts.sv ***
/*
  rms_asserts: port checker for the message sync block.
  Assumes one clock, async active-low reset; bind at the foot.
*/
`timescale 1ns/10ps
module rms_asserts import rms_pkg::*; (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // response stream
  input wire logic [7:0]  txData,
  input wire logic        txValid,
  input wire logic        txReady,
  // status
  input wire rms_cfg_s    cfg,
  input wire logic [15:0] condReg,
  input wire logic [15:0] eventReg,
  input wire logic        srq,
  input wire logic        outputOn
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ========
  // properties
  property p_txHold; txValid && !txReady |=> txValid && $stable(txData); endproperty
  a_txHold: assert property (p_txHold) else $error("tx byte moved early");
  property p_bit3Only; (condReg & 16'hFFF7) == 16'h0000; endproperty
  a_bit3Only: assert property (p_bit3Only) else $error("stray cond bit");
  property p_settleLen; $rose(condReg[3]) |-> condReg[3] [*8]; endproperty
  a_settleLen: assert property (p_settleLen) else $error("settle too short");
  property p_onSettle; $rose(outputOn) |-> ##[0:2] condReg[3]; endproperty
  a_onSettle: assert property (p_onSettle) else $error("no settle on enable");
  property p_fallEv; cfg.filter == FLT_FALL && $fell(condReg[3]) |-> ##[0:2] eventReg[3]; endproperty
  a_fallEv: assert property (p_fallEv) else $error("fall event missed");
  property p_evCause; $rose(eventReg[3]) |-> cfg.filter != FLT_NONE; endproperty
  a_evCause: assert property (p_evCause) else $error("event without filter");
  property p_srqCause; $rose(srq) |-> $past(eventReg) != 16'h0000; endproperty
  a_srqCause: assert property (p_srqCause) else $error("srq without event");
  property p_readClr; $fell(eventReg[3]) |-> ##[0:3] txValid; endproperty
  a_readClr: assert property (p_readClr) else $error("clear without read");
endmodule // rms_asserts

bind rms_remote_message_sync rms_asserts u_chk (.clock, .rst_b, .txData, .txValid,
  .txReady, .cfg, .condReg, .eventReg, .srq, .outputOn);

// *** test/rms_host.sv ***
/*
  rms_host: remote controller model, queues command bytes and
  collects response bytes. Assumes the bench calls send and reads got.
*/
`timescale 1ns/10ps
module rms_host (
  // clock
  input wire logic       clock,
  // command stream
  output logic [7:0]     rxData,
  output logic           rxValid,
  input wire logic       rxReady,
  // response stream
  input wire logic [7:0] txData,
  input wire logic       txValid,
  output logic           txReady,
  // pacing: 0 prompt, 1 stalled, 2 every other cycle
  input wire logic [1:0] pace
);
  byte unsigned sendQ[$];
  byte unsigned got[$];
  logic         acc = 1'b0;
  logic         tog = 1'b0;
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
    txReady = 1'b0;
  end
  task automatic send(input string s);
    foreach (s[i]) sendQ.push_back(s[i]);
  endtask
  // ========
  // sample at the edge, counted by bytes not terminators
  always @(posedge clock) begin
    acc = rxValid && rxReady;
    if (txValid && txReady) got.push_back(txData);
  end
  // idle data line shows the inverse so a stale byte is never reread
  always @(negedge clock) begin
    if (acc) void'(sendQ.pop_front());
    tog = !tog;
    rxValid = sendQ.size() != 0;
    rxData = rxValid ? sendQ[0] : ~rxData;
    txReady = pace == 2'h0 || (pace == 2'h2 && tog);
  end
endmodule // rms_host

// *** test/test_remote_message_sync.sv ***
/*
  test_remote_message_sync: directed bench for the message sync block.
  Assumes a short settle count and the host model on the streams.
*/
`timescale 1ns/10ps
module test_remote_message_sync import rms_pkg::*;;
  localparam int SETTLE = 20;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  rxData, txData;
  logic        rxValid, rxReady, txValid, txReady, srq, outputOn;
  logic [1:0]  pace = 2'h0;
  rms_cfg_s    cfg;
  logic [15:0] condReg, eventReg;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;
  string       all;
  always #25 clock = !clock;
  rms_remote_message_sync #(.SETTLE_CYCLES(SETTLE), .FIFO_DEPTH(RX_DEPTH)) DUT (
    .clock(clock), .rst_b(rst_b), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady), .cfg(cfg), .condReg(condReg),
    .eventReg(eventReg), .srq(srq), .outputOn(outputOn));
  rms_host host (.clock(clock), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady), .pace(pace));
  // ========
  // checks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s exp %h got %h", what, exp, got);
    end
  endtask
  // newlines shown as ~ so a mismatch stays on one line
  function automatic string esc(input string t);
    esc = "";
    foreach (t[i]) begin
      if (t[i] == 8'h0A) esc = {esc, "~"};
      else esc = {esc, t.substr(i, i)};
    end
  endfunction
  // bounded wait for the whole expected text, then compare
  task automatic resp(input string exp);
    string s;
    s = "";
    for (int i = 0; i < 1000 && host.got.size() < exp.len(); i++) @(negedge clock);
    while (host.got.size() != 0) s = $sformatf("%s%c", s, host.got.pop_front());
    checked++;
    if (s != exp) begin
      n_fail++;
      $display("ERROR resp exp %s got %s", esc(exp), esc(s));
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  // ========
  // tests
  initial begin
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    host.send("h\nH0;h\nH1;V1;h\nV0;H0;M1;h\n");
    resp(":h 1\n0\n:hh 1\n0\n");
    chk("remote", 16'h0001, 16'(cfg.remote));
    $display("done settings");
    host.send("T'a''\nb'\nB\n");
    resp("\"a'\nb\"\n#204a'\nb\n");
    $display("done text");
    host.send("F2;E#B1000;S#Q10;R\nL\n");
    resp("0\n");
    for (int i = 0; i < 50 && condReg[3] !== 1'b1; i++) @(negedge clock);
    chk("settle", 16'h0008, condReg);
    for (int i = 0; i < 200 && srq !== 1'b1; i++) @(negedge clock);
    chk("event", 16'h0008, eventReg);
    chk("srq", 16'h0001, 16'(srq));
    host.send("e;R\n");
    resp("8\n8\n");
    chk("cleared", 16'h0000, eventReg);
    $display("done events");
    host.send("O1\n");
    for (int i = 0; i < 50 && condReg[3] !== 1'b1; i++) @(negedge clock);
    chk("outon", 16'h0001, 16'(outputOn));
    repeat (SETTLE / 2) @(negedge clock);
    host.send("L\n");
    repeat (SETTLE * 3 / 4) @(negedge clock);
    chk("restart", 16'h0008, condReg);
    for (int i = 0; i < 100 && eventReg[3] !== 1'b1; i++) @(negedge clock);
    host.send("R\nL;C;W#H0008;h\n");
    resp("8\n8\n0\n");
    chk("waited", 16'h0008, eventReg);
    host.send("R;L;w8\n");
    resp("8\n8\n");
    $display("done wait");
    pace = 2'h1;
    all = "";
    for (int i = 0; i < 20; i++) begin
      host.send("h;");
      all = {all, "0\n"};
    end
    for (int i = 0; i < 200 && rxReady !== 1'b0; i++) @(negedge clock);
    chk("full", 16'h0000, 16'(rxReady));
    pace = 2'h2;
    resp(all);
    pace = 2'h0;
    $display("done fifo");
    host.send("T'q;M0;h\n");
    repeat (100) @(negedge clock);
    chk("unclosed", 16'h0001, 16'(cfg.remote));
    chk("silent", 16'h0000, 16'(host.got.size()));
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    chk("cfgrst", 16'(CFG_RST), 16'(cfg));
    rst_b = 1'b1;
    host.send("h\nF1;L;R\n");
    resp(":h 1\n:R 8\n");
    $display("done reset");
    end_sim();
  end
endmodule // test_remote_message_sync
